// File: bench/sib_ctrl_model.sv
// sib_ctrl_model: behavioural memory controller driving the sdram command pins.
// assumes issue is called at a falling edge; each call covers one rising edge.
`timescale 1ns/1ps
`default_nettype none
module sib_ctrl_model (
    input  wire logic       clk,
    input  wire logic       all_idle,
    output logic            cs_n,
    output logic            ras_n,
    output logic            cas_n,
    output logic            we_n,
    output logic [1:0]      ba,
    output logic            addr_ap
);
    initial begin
        {cs_n, ras_n, cas_n, we_n} = sib_pkg::CMD_NOP;
        ba = 2'h0;
        addr_ap = 1'b0;
    end

    // callers aim terminate only at the bursting bank and send busy banks nothing
    task automatic issue(input logic [3:0] code, input logic [1:0] bank, input logic ap);
        if ((code == sib_pkg::CMD_REF || code == sib_pkg::CMD_LMR) && all_idle !== 1'b1) begin
            {cs_n, ras_n, cas_n, we_n} = sib_pkg::CMD_NOP;
        end else begin
            {cs_n, ras_n, cas_n, we_n} = code;
        end
        ba = bank;
        addr_ap = ap;
        @(negedge clk);
    endtask

    // bank and flag mean nothing under a nop, so they are scrambled, not held
    task automatic idle();
        {cs_n, ras_n, cas_n, we_n} = sib_pkg::CMD_NOP;
        ba = ~ba;
        addr_ap = ~addr_ap;
    endtask
endmodule // sib_ctrl_model
`default_nettype wire

// File: bench/testbench.sv
// testbench: inter-bank command scenarios for sib_top.
// assumes sib_ctrl_model alone drives the command pins; other inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [3:0]         ACT = sib_pkg::CMD_ACT;
    localparam logic [3:0]         RD  = sib_pkg::CMD_READ;
    localparam logic [3:0]         WR  = sib_pkg::CMD_WRITE;
    localparam logic [3:0]         PRE = sib_pkg::CMD_PRE;
    localparam sib_pkg::sib_bank_e IDL = sib_pkg::BK_IDLE;
    localparam sib_pkg::sib_bank_e ACV = sib_pkg::BK_ACTIVE;
    logic        clk = 1'b0, rstn = 1'b0, cke = 1'b1, self_refresh_exit = 1'b0;
    logic [1:0]  cas_latency = 2'h2;
    logic        cs_n, ras_n, cas_n, we_n, addr_ap, all_idle, dq_drive, wr_accept;
    logic [1:0]  ba, dq_bank, wr_bank;
    logic [11:0] bank_states;
    int          mismatches = 0, samples_checked = 0;

    sib_top sib_top_i (.clk, .rstn, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr_ap, .self_refresh_exit,
                       .cas_latency, .bank_states, .all_idle, .dq_drive, .dq_bank, .wr_accept, .wr_bank);
    sib_ctrl_model sib_ctrl_model_i (.clk, .all_idle, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr_ap);

    always #20 clk = ~clk;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [11:0] st(input int b);
        return 12'(bank_states[3*b +: 3]);
    endfunction
    task automatic go(input int n);
        repeat (n) @(negedge clk);
    endtask
    // bounded wait: a bank that never settles shows up as a mismatch
    task automatic reach(input int b, input sib_pkg::sib_bank_e s, input int n);
        for (int k = 0; k < n && bank_states[3*b +: 3] !== s; k++) @(negedge clk);
        check(st(b), 12'(s));
    endtask
    task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic a);
        sib_ctrl_model_i.issue(c, b, a);
    endtask
    task automatic nop();
        sib_ctrl_model_i.idle();
    endtask
    task automatic act1(input int b);
        go(1);
        cmd(ACT, 2'(b), 1'b0);
        check(st(b), 12'(sib_pkg::BK_ACTVG));
        nop();
        reach(b, ACV, 3);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_gate();
        go(1);
        cke = 1'b0;
        cmd(ACT, 2'h0, 1'b0);
        cke = 1'b1;
        cmd(ACT, 2'h1, 1'b0);
        cmd(4'hB, 2'h2, 1'b0);
        cmd(sib_pkg::CMD_NOP, 2'h3, 1'b0);
        self_refresh_exit = 1'b1;
        cmd(sib_pkg::CMD_NOP, 2'h0, 1'b0);
        self_refresh_exit = 1'b0;
        cmd(ACT, 2'h3, 1'b0);
        nop();
        go(2);
        check(bank_states, 12'h000);
    endtask
    task automatic t_act();
        go(1);
        cmd(ACT, 2'h0, 1'b0);
        cmd(ACT, 2'h1, 1'b0);
        nop();
        reach(0, ACV, 3);
        reach(1, ACV, 3);
        cmd(PRE, 2'h2, 1'b0);
        nop();
        check(st(2), 12'(IDL));
    endtask
    task automatic t_rr(input logic [1:0] c);
        go(1);
        cas_latency = c;
        cmd(RD, 2'h0, 1'b0);
        cmd(RD, 2'h1, 1'b0);
        nop();
        go((c == 2'h0) ? 1 : int'(c) - 1);
        check(12'({dq_drive, dq_bank}), 12'h004);
        go(1);
        check(12'({dq_drive, dq_bank}), 12'h005);
        reach(1, ACV, 8);
        check(st(0), 12'(ACV));
    endtask
    task automatic t_bst();
        go(2);
        cas_latency = 2'h2;
        cmd(RD, 2'h1, 1'b0);
        cmd(PRE, 2'h0, 1'b0);
        check(st(1), 12'(sib_pkg::BK_READ));
        cmd(sib_pkg::CMD_BST, 2'h1, 1'b0);
        nop();
        check(st(1), 12'(ACV));
        reach(0, IDL, 3);
        go(4);
        check(12'(dq_drive), 12'h000);
    endtask
    task automatic t_rap();
        act1(0);
        cmd(RD, 2'h0, 1'b1);
        check(st(0), 12'(sib_pkg::BK_READ_AP));
        cmd(RD, 2'h1, 1'b0);
        nop();
        check(st(0), 12'(sib_pkg::BK_PRECH));
        reach(0, IDL, 2);
        reach(1, ACV, 8);
    endtask
    task automatic t_wap();
        act1(0);
        cmd(WR, 2'h0, 1'b1);
        cmd(RD, 2'h1, 1'b0);
        nop();
        go(1);
        check(12'(wr_accept), 12'h000);
        go(1);
        check(12'({dq_drive, dq_bank}), 12'h005);
        reach(0, IDL, 3);
        reach(1, ACV, 8);
    endtask
    task automatic t_ww();
        act1(0);
        cmd(WR, 2'h0, 1'b1);
        cmd(WR, 2'h1, 1'b0);
        nop();
        check(12'(wr_bank), 12'h001);
        reach(0, IDL, 4);
        act1(0);
        cmd(RD, 2'h0, 1'b1);
        cmd(WR, 2'h1, 1'b0);
        nop();
        check(st(0), 12'(sib_pkg::BK_PRECH));
        go(2);
        check(12'(dq_drive), 12'h000);
        reach(0, IDL, 2);
    endtask
    task automatic t_ref();
        go(1);
        cmd(PRE, 2'h0, 1'b1);
        nop();
        reach(1, IDL, 6);
        check(12'(all_idle), 12'h001);
        go(1);
        cmd(sib_pkg::CMD_REF, 2'h0, 1'b0);
        nop();
        go(3);
        check(12'(all_idle), 12'h001);
    endtask

    initial begin
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        check(bank_states, 12'h000);
        check(12'({all_idle, dq_drive}), 12'h002);
        t_gate();
        t_act();
        for (int c = 0; c <= 3; c++) t_rr(2'(c));
        t_bst();
        t_rap();
        t_wap();
        t_ww();
        t_ref();
        wrap_up();
    end

    // the scenarios need under two hundred cycles; this leaves ample margin
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
endmodule // testbench
`default_nettype wire

// File: rtl/sib_bank.sv
// sib_bank: state of one sdram bank under commands to itself and to other banks.
// assumes the decoded command is already gated by clock enable and the exit wait.
`timescale 1ns/1ps
`default_nettype none
module sib_bank #(
    parameter logic [1:0] BANK_ID = 2'h0
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire sib_pkg::sib_cmd_s cmd,
    input  wire logic              is_latest,
    output sib_pkg::sib_bank_e     state,
    output logic                   bursting
);
    sib_pkg::sib_bank_e next_state;
    logic [3:0]         cnt;
    logic [3:0]         next_cnt;
    logic [2:0]         beats;
    logic [2:0]         next_beats;
    logic               wr_rec;
    logic               next_wr_rec;
    logic               mine;
    logic               other_burst;
    logic               done;

    assign mine        = cmd.valid && (cmd.bank == BANK_ID);
    assign other_burst = cmd.valid && (cmd.bank != BANK_ID) && (cmd.rd || cmd.wr);
    assign bursting    = (beats != sib_pkg::BURST_ZERO);
    assign done        = (cnt == sib_pkg::CNT_ONE);

    always_comb begin
        next_state  = state;
        next_cnt    = (cnt != sib_pkg::CNT_ZERO) ? cnt - sib_pkg::CNT_ONE : cnt;
        next_beats  = bursting ? beats - 3'h1 : beats;
        next_wr_rec = wr_rec;
        case (state)
            sib_pkg::BK_IDLE: begin
                if (mine && cmd.act) begin
                    next_state = sib_pkg::BK_ACTVG;
                    next_cnt   = 4'(sib_pkg::TRCD_CYC);
                end
                // a precharge to an idle bank changes nothing
            end
            sib_pkg::BK_ACTVG, sib_pkg::BK_PRECH: begin
                if (done) begin
                    next_state = (state == sib_pkg::BK_ACTVG) ? sib_pkg::BK_ACTIVE : sib_pkg::BK_IDLE;
                end
            end
            sib_pkg::BK_READ_AP, sib_pkg::BK_WRITE_AP: begin
                // bursting: wait for the burst end or an interrupting burst, then recovery/precharge
                if (bursting && other_burst) begin
                    next_beats = sib_pkg::BURST_ZERO;
                    if (state == sib_pkg::BK_WRITE_AP) begin
                        next_wr_rec = 1'b1;
                        next_cnt    = 4'(sib_pkg::TWR_CYC);
                    end else begin
                        next_state = sib_pkg::BK_PRECH;
                        next_cnt   = 4'(sib_pkg::TRP_CYC);
                    end
                end else if (bursting && beats == 3'h1) begin
                    if (state == sib_pkg::BK_WRITE_AP) begin
                        next_wr_rec = 1'b1;
                        next_cnt    = 4'(sib_pkg::TWR_CYC);
                    end else begin
                        next_state = sib_pkg::BK_PRECH;
                        next_cnt   = 4'(sib_pkg::TRP_CYC);
                    end
                end else if (wr_rec && done) begin
                    next_wr_rec = 1'b0;
                    next_state  = sib_pkg::BK_PRECH;
                    next_cnt    = 4'(sib_pkg::TRP_CYC);
                end
            end
            default: begin  // active, read, write
                if (mine && (cmd.rd || cmd.wr)) begin
                    next_beats = sib_pkg::BURST_LEN;
                    if (cmd.ap) begin
                        next_state = cmd.rd ? sib_pkg::BK_READ_AP : sib_pkg::BK_WRITE_AP;
                    end else begin
                        next_state = cmd.rd ? sib_pkg::BK_READ : sib_pkg::BK_WRITE;
                    end
                end else if ((mine && cmd.pre) || (cmd.valid && cmd.pre_all)) begin
                    next_state = sib_pkg::BK_PRECH;
                    next_cnt   = 4'(sib_pkg::TRP_CYC);
                    next_beats = sib_pkg::BURST_ZERO;
                end else if ((cmd.valid && cmd.bst && is_latest) || other_burst) begin
                    next_beats = sib_pkg::BURST_ZERO;
                    if (state != sib_pkg::BK_ACTIVE) next_state = sib_pkg::BK_ACTIVE;
                end else if (state != sib_pkg::BK_ACTIVE && beats == 3'h1) begin
                    next_state = sib_pkg::BK_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state  <= sib_pkg::BK_IDLE;
            cnt    <= sib_pkg::CNT_ZERO;
            beats  <= sib_pkg::BURST_ZERO;
            wr_rec <= 1'b0;
        end else begin
            state  <= next_state;
            cnt    <= next_cnt;
            beats  <= next_beats;
            wr_rec <= next_wr_rec;
        end
    end

    chk_pre_idle_hold: assert property (@(posedge clk) disable iff (!rstn)
        (state == sib_pkg::BK_IDLE && mine && cmd.pre) |=> state == sib_pkg::BK_IDLE)
        else $error("precharge to idle bank changed its state");

    chk_pre_other_keeps: assert property (@(posedge clk) disable iff (!rstn)
        ((state == sib_pkg::BK_READ || state == sib_pkg::BK_WRITE) && beats > 3'h1 && cmd.valid && cmd.pre && !mine)
        |=> bursting && state == $past(state))
        else $error("precharge to another bank disturbed the burst");

    chk_wr_ap_recover: assert property (@(posedge clk) disable iff (!rstn)
        (state == sib_pkg::BK_WRITE_AP && bursting && other_burst) |=> wr_rec && state == sib_pkg::BK_WRITE_AP)
        else $error("interrupted auto precharge write skipped write recovery");
endmodule // sib_bank
`default_nettype wire

// File: rtl/sib_pkg.sv
// sib_pkg: constants and types for the four-bank sdram command/state tracker.
// assumes a single 25 MHz clock; commands are sampled on its rising edge.
package sib_pkg;

    // ----------------------------------------
    // geometry and timing
    // ----------------------------------------
    localparam int          NUM_BANKS    = 4;
    localparam int          CLK_PERIOD_NS = 40;
    localparam int          TRP_NS       = 20;
    localparam int          TRCD_NS      = 20;
    localparam int          TWR_NS       = 14;
    localparam int          TXSR_NS      = 80;
    localparam int          TRP_CYC      = ((TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                                           ((TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int          TRCD_CYC     = ((TRCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                                           ((TRCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int          TWR_CYC      = ((TWR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                                           ((TWR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int          TXSR_CYC     = ((TXSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                                           ((TXSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int          CNT_W        = 4;
    localparam logic [3:0]  CNT_ZERO     = 4'h0;
    localparam logic [3:0]  CNT_ONE      = 4'h1;
    localparam logic [2:0]  BURST_LEN    = 3'h4;
    localparam logic [2:0]  BURST_ZERO   = 3'h0;
    localparam logic [1:0]  CL_DEFAULT   = 2'h2;

    // ----------------------------------------
    // command encodings {cs_n, ras_n, cas_n, we_n}
    // ----------------------------------------
    localparam logic [3:0]  CMD_NOP      = 4'h7;
    localparam logic [3:0]  CMD_ACT      = 4'h3;
    localparam logic [3:0]  CMD_READ     = 4'h5;
    localparam logic [3:0]  CMD_WRITE    = 4'h4;
    localparam logic [3:0]  CMD_BST      = 4'h6;
    localparam logic [3:0]  CMD_PRE      = 4'h2;
    localparam logic [3:0]  CMD_REF      = 4'h1;
    localparam logic [3:0]  CMD_LMR      = 4'h0;

    typedef enum logic [2:0] {
        BK_IDLE    = 3'b000,
        BK_ACTVG   = 3'b001,
        BK_ACTIVE  = 3'b010,
        BK_READ    = 3'b011,
        BK_WRITE   = 3'b100,
        BK_READ_AP = 3'b101,
        BK_WRITE_AP= 3'b110,
        BK_PRECH   = 3'b111
    } sib_bank_e;

    // decoded command broadcast to every bank
    typedef struct packed {
        logic       valid;
        logic       act;
        logic       rd;
        logic       wr;
        logic       pre;
        logic       pre_all;
        logic       bst;
        logic       ap;
        logic [1:0] bank;
    } sib_cmd_s;

endpackage

// File: rtl/sib_top.sv
// sib_top: inter-bank command handling of a four-bank sdram, device side.
// assumes the pins are synchronous to clk; only bank states and data ownership are modelled.
`timescale 1ns/1ps
`default_nettype none
module sib_top (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       cke,
    input  wire logic       cs_n,
    input  wire logic       ras_n,
    input  wire logic       cas_n,
    input  wire logic       we_n,
    input  wire logic [1:0] ba,
    input  wire logic       addr_ap,
    input  wire logic       self_refresh_exit,
    input  wire logic [1:0] cas_latency,
    output logic [11:0]     bank_states,
    output logic            all_idle,
    output logic            dq_drive,
    output logic [1:0]      dq_bank,
    output logic            wr_accept,
    output logic [1:0]      wr_bank
);
    // ----------------------------------------
    // command decode
    // ----------------------------------------
    logic               cke_q;
    logic               next_cke_q;
    logic [3:0]         xsr_cnt;
    logic [3:0]         next_xsr_cnt;
    logic [3:0]         pins;
    logic               enabled;
    sib_pkg::sib_cmd_s  cmd;

    assign pins    = {cs_n, ras_n, cas_n, we_n};
    assign enabled = cke && cke_q && (xsr_cnt == sib_pkg::CNT_ZERO);

    always_comb begin
        next_cke_q   = cke;
        next_xsr_cnt = (xsr_cnt != sib_pkg::CNT_ZERO) ? xsr_cnt - sib_pkg::CNT_ONE : xsr_cnt;
        if (self_refresh_exit) next_xsr_cnt = 4'(sib_pkg::TXSR_CYC);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cke_q   <= 1'b0;
            xsr_cnt <= sib_pkg::CNT_ZERO;
        end else begin
            cke_q   <= next_cke_q;
            xsr_cnt <= next_xsr_cnt;
        end
    end

    always_comb begin
        cmd         = '0;
        // cs_n high (inhibit) and the nop pattern decode to nothing
        cmd.valid   = enabled && !cs_n && (pins != sib_pkg::CMD_NOP);
        cmd.act     = pins == sib_pkg::CMD_ACT;
        cmd.rd      = pins == sib_pkg::CMD_READ;
        cmd.wr      = pins == sib_pkg::CMD_WRITE;
        cmd.bst     = pins == sib_pkg::CMD_BST;
        cmd.pre     = (pins == sib_pkg::CMD_PRE) && !addr_ap;
        cmd.pre_all = (pins == sib_pkg::CMD_PRE) && addr_ap;
        cmd.ap      = addr_ap;
        cmd.bank    = ba;
    end

    // ----------------------------------------
    // banks
    // ----------------------------------------
    sib_pkg::sib_bank_e [3:0] st;
    logic [3:0]               bursting;
    logic [1:0]               latest;
    logic [1:0]               next_latest;

    // burst terminate targets whichever bank started the newest burst
    always_comb begin
        next_latest = latest;
        if (cmd.valid && (cmd.rd || cmd.wr)) next_latest = cmd.bank;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) latest <= 2'h0;
        else       latest <= next_latest;
    end

    genvar gi;
    generate
        for (gi = 0; gi < sib_pkg::NUM_BANKS; gi++) begin : g_bank
            sib_bank #(.BANK_ID(2'(gi))) u_bank (
                .clk       (clk),
                .rstn      (rstn),
                .cmd       (cmd),
                .is_latest (latest == 2'(gi)),
                .state     (st[gi]),
                .bursting  (bursting[gi])
            );
            assign bank_states[gi*3 +: 3] = st[gi];
        end
    endgenerate

    assign all_idle = (st[0] == sib_pkg::BK_IDLE) && (st[1] == sib_pkg::BK_IDLE) &&
                      (st[2] == sib_pkg::BK_IDLE) && (st[3] == sib_pkg::BK_IDLE);

    // ----------------------------------------
    // data ownership
    // ----------------------------------------
    // a read owns dq cas latency after it is registered; a write takes dq from the next edge.
    // the pipe keeps one slot per latency step so an interrupting read replaces the old owner
    // exactly when its own first word appears, never earlier.
    logic [2:0]         rd_pipe_v;
    logic [2:0]         next_rd_pipe_v;
    logic [1:0]         rd_pipe_b [3];
    logic [1:0]         next_rd_pipe_b [3];
    logic [2:0]         rd_beats;
    logic [2:0]         next_rd_beats;
    logic [2:0]         wr_beats;
    logic [2:0]         next_wr_beats;
    logic [1:0]         next_dq_bank;
    logic [1:0]         next_wr_bank;
    logic [1:0]         lat;
    logic               new_rd;
    logic               new_wr;
    logic               cut;

    assign lat    = (cas_latency == 2'h0) ? sib_pkg::CL_DEFAULT : cas_latency;
    assign new_rd = cmd.valid && cmd.rd;
    assign new_wr = cmd.valid && cmd.wr;
    assign cut    = cmd.valid && cmd.bst;

    always_comb begin
        // every slot moves one step toward the head at slot 0 on each edge
        next_rd_pipe_v = {1'b0, rd_pipe_v[2:1]};
        next_rd_pipe_b[0] = rd_pipe_b[1];
        next_rd_pipe_b[1] = rd_pipe_b[2];
        next_rd_pipe_b[2] = 2'h0;
        next_rd_beats  = (rd_beats != sib_pkg::BURST_ZERO) ? rd_beats - 3'h1 : rd_beats;
        next_dq_bank   = dq_bank;
        next_wr_beats  = (wr_beats != sib_pkg::BURST_ZERO) ? wr_beats - 3'h1 : wr_beats;
        next_wr_bank   = wr_bank;
        if (new_rd) begin
            // slot index lat-1 reaches the head after lat edges
            if (lat == 2'h1) begin
                next_rd_pipe_v[0] = 1'b1;
                next_rd_pipe_b[0] = cmd.bank;
            end else if (lat == 2'h2) begin
                next_rd_pipe_v[1] = 1'b1;
                next_rd_pipe_b[1] = cmd.bank;
            end else begin
                next_rd_pipe_v[2] = 1'b1;
                next_rd_pipe_b[2] = cmd.bank;
            end
        end
        // write data ends at the interrupting command's edge
        if (new_rd || cut) next_wr_beats = sib_pkg::BURST_ZERO;
        if (new_wr) begin
            next_wr_beats = sib_pkg::BURST_LEN;
            next_wr_bank  = cmd.bank;
        end
        // reads are cut at once by a write or terminate
        if (new_wr || cut) begin
            next_rd_beats  = sib_pkg::BURST_ZERO;
            next_rd_pipe_v = 3'h0;
        end else if (rd_pipe_v[0]) begin
            next_rd_beats = sib_pkg::BURST_LEN;
            next_dq_bank  = rd_pipe_b[0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_pipe_v <= 3'h0;
            rd_pipe_b <= '{2'h0, 2'h0, 2'h0};
            rd_beats  <= sib_pkg::BURST_ZERO;
            dq_bank   <= 2'h0;
            wr_beats  <= sib_pkg::BURST_ZERO;
            wr_bank   <= 2'h0;
        end else begin
            rd_pipe_v <= next_rd_pipe_v;
            rd_pipe_b <= next_rd_pipe_b;
            rd_beats  <= next_rd_beats;
            dq_bank   <= next_dq_bank;
            wr_beats  <= next_wr_beats;
            wr_bank   <= next_wr_bank;
        end
    end

    assign dq_drive  = (rd_beats != sib_pkg::BURST_ZERO);
    assign wr_accept = (wr_beats != sib_pkg::BURST_ZERO);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // interrupt checks watch the newest burst's bank: only that one can still be running
    sequence s_rd_interrupt_ap;
        new_rd && st[latest] == sib_pkg::BK_READ_AP && bursting[latest] && cmd.bank != latest;
    endsequence

    sequence s_wr_interrupt_rd_ap;
        new_wr && st[latest] == sib_pkg::BK_READ_AP && bursting[latest] && cmd.bank != latest;
    endsequence

    sequence s_any_interrupt_wr_ap;
        (new_rd || new_wr) && st[latest] == sib_pkg::BK_WRITE_AP && bursting[latest] && cmd.bank != latest;
    endsequence

    // quiet edges after the read so that no other command can claim dq meanwhile
    sequence s_rd_quiet_cl2;
        (new_rd && lat == 2'h2) ##1 (!cmd.valid)[*2];
    endsequence

    sequence s_rd_quiet_cl1;
        (new_rd && lat == 2'h1) ##1 !cmd.valid;
    endsequence

    chk_inhibit_quiet: assert property (@(posedge clk) disable iff (!rstn)
        (cs_n && all_idle) |=> $stable(bank_states))
        else $error("inhibit disturbed the banks");

    chk_nop_quiet: assert property (@(posedge clk) disable iff (!rstn)
        (!cs_n && pins == sib_pkg::CMD_NOP && all_idle) |=> $stable(bank_states))
        else $error("nop disturbed the banks");

    chk_cke_gate: assert property (@(posedge clk) disable iff (!rstn)
        (!cke_q || !cke) |-> !cmd.valid)
        else $error("command taken with clock enable low");

    chk_exit_wait: assert property (@(posedge clk) disable iff (!rstn)
        (xsr_cnt != sib_pkg::CNT_ZERO) |-> !cmd.valid)
        else $error("command taken during self refresh exit wait");

    chk_act_idle: assert property (@(posedge clk) disable iff (!rstn)
        (cmd.valid && cmd.act && st[cmd.bank] == sib_pkg::BK_IDLE) |=> st[$past(ba)] == sib_pkg::BK_ACTVG)
        else $error("activate did not start row activation");

    chk_rd_switch: assert property (@(posedge clk) disable iff (!rstn)
        s_rd_quiet_cl2 |=> dq_bank == $past(ba, 3) && dq_drive)
        else $error("read data owner did not switch after cas latency");

    chk_rd_switch_cl1: assert property (@(posedge clk) disable iff (!rstn)
        s_rd_quiet_cl1 |=> dq_bank == $past(ba, 2) && dq_drive)
        else $error("read data owner did not switch after one cycle latency");

    chk_wr_cuts_rd: assert property (@(posedge clk) disable iff (!rstn)
        new_wr |=> !dq_drive)
        else $error("write did not cut the running read");

    chk_rd_stops_wr: assert property (@(posedge clk) disable iff (!rstn)
        (new_rd && !new_wr) |=> !wr_accept)
        else $error("read did not stop the running write");

    chk_wr_takes_wr: assert property (@(posedge clk) disable iff (!rstn)
        new_wr |=> wr_accept && wr_bank == $past(ba))
        else $error("write did not take over the data input");

    chk_bst_cuts: assert property (@(posedge clk) disable iff (!rstn)
        cut |=> !dq_drive && !wr_accept)
        else $error("burst terminate left a burst running");

    chk_latest_track: assert property (@(posedge clk) disable iff (!rstn)
        (new_rd || new_wr) |=> latest == $past(ba))
        else $error("newest burst bank not tracked");

    chk_ap_prech: assert property (@(posedge clk) disable iff (!rstn)
        s_rd_interrupt_ap |=> st[$past(latest)] == sib_pkg::BK_PRECH)
        else $error("interrupted auto precharge read did not start precharge");

    chk_wr_cuts_rd_ap: assert property (@(posedge clk) disable iff (!rstn)
        s_wr_interrupt_rd_ap |=> st[$past(latest)] == sib_pkg::BK_PRECH)
        else $error("write over auto precharge read did not start precharge");

    chk_wr_ap_wait: assert property (@(posedge clk) disable iff (!rstn)
        s_any_interrupt_wr_ap |=> st[$past(latest)] == sib_pkg::BK_WRITE_AP)
        else $error("interrupted auto precharge write skipped write recovery");

    chk_prech_ends: assert property (@(posedge clk) disable iff (!rstn)
        (st[0] == sib_pkg::BK_PRECH && $past(st[0]) != sib_pkg::BK_PRECH) |-> ##1 st[0] == sib_pkg::BK_IDLE)
        else $error("precharge did not end after precharge time");
endmodule // sib_top
`default_nettype wire
